// ===== rtl/frp_cmd.sv
`timescale 1ns/1ps
// Behaviour
// - Software reset reloads all volatile defaults
// - Software reset aborts running internal operation
// - Reset ignored in power-down and recovery
// - Reset ignored during continuous read mode
// - Reset is 66h then 99h, at deselect
// - Other opcode after 66h clears enable
// - B9h exact eight bits enters power-down
// - Power-down decodes only release ABh
// - Power-up state is normal, not power-down
// - Release accepts commands after recovery time
// - ABh with dummies shifts device ID repeatedly
// - ABh ignored while busy
// - 90h returns IDs alternating, order by address
// - 9Fh, or AFh in QPI mode only, returns manufacturer, type, capacity
// - Capture bits on rising serial clock
module frp_cmd #(
    parameter int         RST_CYCLES  = frp_pkg::RST_CYC,
    parameter logic [7:0] MFR_ID      = frp_pkg::MFR_ID_DEF,
    parameter logic [7:0] DEV_ID      = frp_pkg::DEV_ID_DEF,
    parameter logic [7:0] MEM_TYPE    = frp_pkg::MTYPE_DEF,
    parameter logic [7:0] CAPACITY    = frp_pkg::CAP_DEF
) (
    input  wire logic       REF_CLK,
    input  wire logic       RST,
    input  wire logic       CS_N,
    input  wire logic       SCLK,
    input  wire logic       DI,
    input  wire logic       QPI_MODE,
    input  wire logic       BUSY,
    input  wire logic [1:0] CONT_READ_MODE_BITS,
    input  wire logic       CONT_READ_ACTIVE,
    output logic            DO,
    output logic            DO_OE,
    output logic            DEEP_SLEEP,
    output logic            RECOVERING,
    output logic            ABORT_OP,
    output logic            SOFT_RESET,
    output logic            WRITE_PERMIT_LATCH_CLR,
    output logic [7:0]      READ_PARAMETER_BITS,
    output logic [2:0]      WRAP_LENGTH_BITS
);
    localparam int CW = 16;
    // Two-stage synchronisers for pins
    logic [1:0] cs_sync_reg, clk_sync_reg, di_sync_reg;
    logic       cs_n_s, sclk_s, di_s, sclk_d_reg, cs_d_reg;
    logic       rise, fall, cs_rise;
    frp_pkg::frp_state_t state_reg;
    frp_pkg::frp_src_t   src_reg;
    logic [7:0]    sh_reg, out_reg;
    logic [2:0]    bit_reg;
    logic [1:0]    byte_reg, idx_reg;
    logic          any_nonzero_reg, addr_lsb_reg;
    logic          rst_en_reg, rst_arm_reg, dp_arm_reg, rel_arm_reg, rel_id_reg;
    logic          dp_reg, dp_pend_reg, rec_reg;
    logic [CW-1:0] tmr_reg, rch_reg;
    logic          rst_busy_reg;
    logic          do_reg, oe_reg, abort_reg, sreset_reg;
    logic [7:0]    rp_reg;
    logic [2:0]    wrap_reg;

    // Pin synchronisers: first stage read only by second stage
    always_ff @(posedge REF_CLK) begin
        cs_sync_reg  <= {cs_sync_reg[0], CS_N};
        clk_sync_reg <= {clk_sync_reg[0], SCLK};
        di_sync_reg  <= {di_sync_reg[0], DI};
        sclk_d_reg   <= clk_sync_reg[1];
        cs_d_reg     <= cs_sync_reg[1];
    end

    assign cs_n_s  = cs_sync_reg[1];
    assign sclk_s  = clk_sync_reg[1];
    assign di_s    = di_sync_reg[1];
    assign rise    = !cs_n_s && sclk_s && !sclk_d_reg;
    assign fall    = !cs_n_s && !sclk_s && sclk_d_reg;
    assign cs_rise = cs_n_s && !cs_d_reg;

    // Decode helpers
    wire [7:0] byte_in   = {sh_reg[6:0], di_s};
    wire       byte_done = rise && (bit_reg == 3'h7);
    wire       blocked   = dp_reg || dp_pend_reg || rec_reg || rst_busy_reg;
    wire       ident_op  = (byte_in == frp_pkg::OP_IDENT) ||
                           (QPI_MODE && byte_in == frp_pkg::OP_IDENT_QPI);
    wire       rst_ok    = !dp_reg && !dp_pend_reg && !rec_reg && !CONT_READ_ACTIVE
                           && CONT_READ_MODE_BITS != frp_pkg::CRM_ACTIVE;
    wire       rch_met   = rch_reg >= CW'(frp_pkg::RCH_CYC);
    // A wake-up release must survive its dummies and the ID read that follows
    wire       keep_rel  = (state_reg == frp_pkg::ST_DUMMY) ||
                           (state_reg == frp_pkg::ST_SHIFT_OUT);

    function automatic logic [7:0] id_byte(input frp_pkg::frp_src_t s, input logic [1:0] i,
                                           input logic first_dev);
        logic [7:0] r;
        r = DEV_ID;
        unique case (s)
            frp_pkg::SRC_DEV:     r = DEV_ID;
            frp_pkg::SRC_MFR_DEV: r = (i[0] ^ first_dev) ? DEV_ID : MFR_ID;
            frp_pkg::SRC_JEDEC:   r = (i == 2'h0) ? MFR_ID :
                                      (i == 2'h1) ? MEM_TYPE : CAPACITY;
        endcase
        return r;
    endfunction : id_byte

    // Next identifier byte once the current one is fully shifted
    wire [1:0] nx_idx  = (src_reg == frp_pkg::SRC_JEDEC &&
                          idx_reg == 2'(frp_pkg::JEDEC_BYTES - 1)) ? 2'h0 : idx_reg + 2'h1;
    wire [7:0] nx_byte = id_byte(src_reg, nx_idx, addr_lsb_reg);

    // Command decoder and output shifter
    always_ff @(posedge REF_CLK) begin
        if (RST || cs_n_s) begin
            state_reg <= frp_pkg::ST_OPCODE;
            bit_reg <= 3'h0;
            sh_reg <= 8'h00;
            byte_reg <= 2'h0;
            idx_reg <= 2'h0;
            oe_reg <= 1'b0;
            do_reg <= 1'b0;
            out_reg <= 8'h00;
            src_reg <= frp_pkg::SRC_DEV;
            any_nonzero_reg <= 1'b0;
            addr_lsb_reg <= 1'b0;
            rch_reg <= '0;
            if (RST || cs_rise) begin
                rst_arm_reg <= 1'b0;
                dp_arm_reg  <= 1'b0;
                rel_arm_reg <= 1'b0;
                rel_id_reg  <= 1'b0;
            end
            if (RST) begin
                rst_en_reg <= 1'b0;
            end
        end else begin
            if (rst_arm_reg && !rch_met) begin
                rch_reg <= rch_reg + CW'(1);
            end
            if (rise) begin
                sh_reg  <= byte_in;
                bit_reg <= bit_reg + 3'h1;
                if (state_reg != frp_pkg::ST_OPCODE) begin
                    rst_arm_reg <= 1'b0;
                    dp_arm_reg  <= 1'b0;
                    if (!keep_rel) begin
                        rel_arm_reg <= 1'b0;
                    end
                end
            end
            if (byte_done) begin
                unique case (state_reg)
                    frp_pkg::ST_OPCODE: begin
                        state_reg <= frp_pkg::ST_DONE;
                        if (dp_reg) begin
                            // Only release is decoded in deep sleep
                            if (byte_in == frp_pkg::OP_RELEASE && !BUSY) begin
                                rel_arm_reg <= 1'b1;
                                state_reg <= frp_pkg::ST_DUMMY;
                            end else begin
                                state_reg <= frp_pkg::ST_IGNORE;
                            end
                        end else if (blocked) begin
                            state_reg <= frp_pkg::ST_IGNORE;
                        end else begin
                            rst_en_reg <= (byte_in == frp_pkg::OP_RESET_EN) && rst_ok;
                            if (byte_in == frp_pkg::OP_RESET && rst_en_reg && rst_ok) begin
                                rst_arm_reg <= 1'b1;
                            end
                            if (byte_in == frp_pkg::OP_DEEP_SLEEP) begin
                                dp_arm_reg <= 1'b1;
                            end
                            if (byte_in == frp_pkg::OP_RELEASE && !BUSY) begin
                                src_reg <= frp_pkg::SRC_DEV;
                                state_reg <= frp_pkg::ST_DUMMY;
                            end
                            if (byte_in == frp_pkg::OP_MFR_DEV) begin
                                src_reg <= frp_pkg::SRC_MFR_DEV;
                                state_reg <= frp_pkg::ST_ADDR;
                            end
                            if (ident_op) begin
                                src_reg <= frp_pkg::SRC_JEDEC;
                                out_reg <= id_byte(frp_pkg::SRC_JEDEC, 2'h0, 1'b0);
                                state_reg <= frp_pkg::ST_SHIFT_OUT;
                            end
                        end
                    end
                    frp_pkg::ST_ADDR, frp_pkg::ST_DUMMY: begin
                        byte_reg <= byte_reg + 2'h1;
                        if (state_reg == frp_pkg::ST_DUMMY) begin
                            rel_id_reg <= 1'b1;
                        end
                        if (byte_reg == 2'(frp_pkg::ADDR_BYTES - 1)) begin
                            out_reg <= id_byte(src_reg, 2'h0, byte_in[0]);
                            addr_lsb_reg <= byte_in[0];
                            state_reg <= frp_pkg::ST_SHIFT_OUT;
                        end
                    end
                    default: ;
                endcase
            end
            // Falling edge drives next output bit, MSB first
            if (fall && state_reg == frp_pkg::ST_SHIFT_OUT) begin
                oe_reg <= 1'b1;
                do_reg <= out_reg[7];
                out_reg <= {out_reg[6:0], 1'b0};
                if (bit_reg == 3'h0 && oe_reg) begin
                    // Byte finished; load next and emit its MSB
                    idx_reg <= nx_idx;
                    do_reg  <= nx_byte[7];
                    out_reg <= {nx_byte[6:0], 1'b0};
                end
            end
        end
    end

    // Power state, timers and software reset effects
    always_ff @(posedge REF_CLK) begin
        abort_reg  <= 1'b0;
        sreset_reg <= 1'b0;
        if (RST) begin
            dp_reg <= 1'b0;
            dp_pend_reg <= 1'b0;
            rec_reg <= 1'b0;
            rst_busy_reg <= 1'b0;
            tmr_reg <= '0;
            rp_reg <= frp_pkg::RP_RESET;
            wrap_reg <= frp_pkg::WRAP_RESET;
        end else begin
            if (tmr_reg != '0) begin
                tmr_reg <= tmr_reg - CW'(1);
            end else begin
                rec_reg <= 1'b0;
                rst_busy_reg <= 1'b0;
                if (dp_pend_reg) begin
                    dp_pend_reg <= 1'b0;
                    dp_reg <= 1'b1;
                end
            end
            if (cs_rise && rst_arm_reg && rch_met && bit_reg == 3'h0) begin
                abort_reg <= 1'b1;
                sreset_reg <= 1'b1;
                rp_reg <= frp_pkg::RP_RESET;
                wrap_reg <= frp_pkg::WRAP_RESET;
                rst_busy_reg <= 1'b1;
                tmr_reg <= CW'(RST_CYCLES);
            end else if (cs_rise && dp_arm_reg && bit_reg == 3'h0) begin
                dp_pend_reg <= 1'b1;
                tmr_reg <= CW'(frp_pkg::DP_CYC);
            end else if (cs_rise && rel_arm_reg && dp_reg) begin
                dp_reg <= 1'b0;
                rec_reg <= 1'b1;
                tmr_reg <= rel_id_reg ? CW'(frp_pkg::RES2_CYC) : CW'(frp_pkg::RES1_CYC);
            end
        end
    end

    // Outputs straight from flip-flops
    assign DO = do_reg;
    assign DO_OE = oe_reg;
    assign DEEP_SLEEP = dp_reg;
    assign RECOVERING = rec_reg;
    assign ABORT_OP = abort_reg;
    assign SOFT_RESET = sreset_reg;
    assign WRITE_PERMIT_LATCH_CLR = sreset_reg;
    assign READ_PARAMETER_BITS = rp_reg;
    assign WRAP_LENGTH_BITS = wrap_reg;
endmodule : frp_cmd

// ===== rtl/frp_pkg.sv
package frp_pkg;
    // Opcodes
    localparam logic [7:0] OP_RESET_EN   = 8'h66;
    localparam logic [7:0] OP_RESET      = 8'h99;
    localparam logic [7:0] OP_DEEP_SLEEP = 8'hB9;
    localparam logic [7:0] OP_RELEASE    = 8'hAB;
    localparam logic [7:0] OP_MFR_DEV    = 8'h90;
    localparam logic [7:0] OP_IDENT      = 8'h9F;
    localparam logic [7:0] OP_IDENT_QPI  = 8'hAF;
    // Continuous read mode bits value that keeps the mode active
    localparam logic [1:0] CRM_ACTIVE    = 2'h2;
    // Field counts
    localparam int         DUMMY_BYTES   = 3;
    localparam int         ADDR_BYTES    = 3;
    localparam int         JEDEC_BYTES   = 3;
    // Reset values of volatile settings
    localparam logic [7:0] RP_RESET      = 8'h00;
    localparam logic [2:0] WRAP_RESET    = 3'h1;
    // Timing in ns, cycle counts derived from 125 MHz clock
    localparam int         CLK_NS        = 8;
    localparam int         RCH_NS        = 16;
    localparam int         DP_NS         = 3000;
    localparam int         RES1_NS       = 3000;
    localparam int         RES2_NS       = 3000;
    localparam int         RST_NS        = 30000;
    localparam int         RCH_CYC       = (RCH_NS + CLK_NS - 1) / CLK_NS;
    localparam int         DP_CYC        = DP_NS / CLK_NS;
    localparam int         RES1_CYC      = (RES1_NS + CLK_NS - 1) / CLK_NS;
    localparam int         RES2_CYC      = (RES2_NS + CLK_NS - 1) / CLK_NS;
    localparam int         RST_CYC       = (RST_NS + CLK_NS - 1) / CLK_NS;
    // Neutral identity defaults (values arbitrary)
    localparam logic [7:0] MFR_ID_DEF    = 8'h5A;
    localparam logic [7:0] DEV_ID_DEF    = 8'h16;
    localparam logic [7:0] MTYPE_DEF     = 8'h60;
    localparam logic [7:0] CAP_DEF       = 8'h17;
    // Decoder states
    typedef enum logic [2:0] {
        ST_OPCODE, ST_ADDR, ST_DUMMY, ST_SHIFT_OUT, ST_DONE, ST_IGNORE
    } frp_state_t;
    // Outgoing data source
    typedef enum logic [1:0] {SRC_DEV, SRC_MFR_DEV, SRC_JEDEC} frp_src_t;
endpackage : frp_pkg

// ===== verification/frp_cmd_sva.sv
`timescale 1ns/1ps
// Port-level checks for the command block
module frp_cmd_sva #(
    parameter int RST_CYCLES = frp_pkg::RST_CYC
) (
    input wire logic       REF_CLK,
    input wire logic       RST,
    input wire logic       CS_N,
    input wire logic [1:0] CONT_READ_MODE_BITS,
    input wire logic       CONT_READ_ACTIVE,
    input wire logic       DO_OE,
    input wire logic       DEEP_SLEEP,
    input wire logic       RECOVERING,
    input wire logic       ABORT_OP,
    input wire logic       SOFT_RESET,
    input wire logic       WRITE_PERMIT_LATCH_CLR,
    input wire logic [7:0] READ_PARAMETER_BITS,
    input wire logic [2:0] WRAP_LENGTH_BITS
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RST);

    // Cycles since the last soft reset, saturating at the busy time
    int since_rst;
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            since_rst <= RST_CYCLES;
        end else if (SOFT_RESET) begin
            since_rst <= 0;
        end else if (since_rst < RST_CYCLES) begin
            since_rst <= since_rst + 1;
        end
    end

    busy_quiet_a: assert property (since_rst < RST_CYCLES |-> !$rose(DO_OE))
        else $error("output started during reset busy time");
    // Soft reset side effects
    pulse_pair_a: assert property (SOFT_RESET |-> ABORT_OP && WRITE_PERMIT_LATCH_CLR)
        else $error("abort or latch clear missing");
    defaults_back_a: assert property (SOFT_RESET |=> READ_PARAMETER_BITS == frp_pkg::RP_RESET
        && WRAP_LENGTH_BITS == frp_pkg::WRAP_RESET) else $error("volatile defaults not reloaded");
    single_pulse_a: assert property (SOFT_RESET |=> !SOFT_RESET [*8])
        else $error("soft reset pulse too long");
    on_deselect_a: assert property (SOFT_RESET |-> CS_N && $past(CS_N))
        else $error("soft reset while selected");
    // Blocking conditions
    sleep_block_a: assert property (DEEP_SLEEP || RECOVERING |-> !SOFT_RESET)
        else $error("soft reset in power-down");
    crm_block_a: assert property (SOFT_RESET |-> !CONT_READ_ACTIVE
        && CONT_READ_MODE_BITS != 2'h2) else $error("soft reset in continuous read");
    sleep_entry_a: assert property ($rose(DEEP_SLEEP) |-> CS_N)
        else $error("power-down entered while selected");
    wake_normal_a: assert property ($fell(RST) |-> !DEEP_SLEEP)
        else $error("power-down after reset");
    oe_idle_a: assert property (CS_N [*6] |-> !DO_OE)
        else $error("output driven while deselected");
endmodule : frp_cmd_sva

bind frp_cmd frp_cmd_sva #(.RST_CYCLES(RST_CYCLES)) u_frp_cmd_sva (.REF_CLK, .RST, .CS_N,
    .CONT_READ_MODE_BITS, .CONT_READ_ACTIVE, .DO_OE, .DEEP_SLEEP, .RECOVERING, .ABORT_OP,
    .SOFT_RESET, .WRITE_PERMIT_LATCH_CLR, .READ_PARAMETER_BITS, .WRAP_LENGTH_BITS);

// ===== verification/frp_host.sv
`timescale 1ns/1ps
// Host model: mode-0 serial master, link clock still and low between frames
module frp_host (
    input  wire logic clk,
    output logic      cs_n,
    output logic      sclk,
    output logic      di,
    input  wire logic do_pin,
    input  wire logic do_oe,
    input  wire logic soft_reset
);
    logic [25:0] res;
    event        done;

    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        di   = 1'b0;
    end

    // Flags gathered over a frame and its tail
    // Sampled on the falling edge, where the block's flops have settled
    always @(negedge clk) begin
        if (!cs_n && do_oe) res[24] = 1'b1;
        if (soft_reset) res[25] = 1'b1;
    end

    // Half period of 5 clocks gives the 80 ns link clock
    task automatic frame(input logic [31:0] tx, input int nb, input int nr, input int hold);
        @(negedge clk);
        // Cleared only now so the previous result is read before it goes
        res = '0;
        cs_n = 1'b0;
        for (int i = 0; i < nb + nr; i++) begin
            di = (i < nb) ? tx[31-i] : ~di;
            sclk = 1'b0;
            repeat (5) @(negedge clk);
            sclk = 1'b1;
            if (i >= nb) res[23:0] = {res[22:0], do_oe & do_pin};
            repeat ((i == nb + nr - 1) ? hold : 5) @(negedge clk);
        end
        sclk = 1'b0;
        cs_n = 1'b1;
        di = ~di;
        // Select stays high long enough for the reset busy time
        repeat (30) @(negedge clk);
        -> done;
    endtask : frame
endmodule : frp_host

// ===== verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    localparam logic [7:0] MF = frp_pkg::MFR_ID_DEF;
    localparam logic [7:0] DV = frp_pkg::DEV_ID_DEF;
    localparam logic [7:0] MT = frp_pkg::MTYPE_DEF;
    localparam logic [7:0] CP = frp_pkg::CAP_DEF;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        qpi = 1'b0;
    logic        busy = 1'b0;
    logic [1:0]  crm = 2'h0;
    logic        cra = 1'b0;
    wire         cs_n, sclk, di, dout, doe, srst;
    wire         ds, rec;
    wire  [7:0]  rpb;
    wire  [2:0]  wlb;
    logic [25:0] exp_q[$];
    int          fail_count = 0;
    int          compares = 0;
    int          cycles = 0;

    always #4 clk = ~clk;

    frp_host host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .di(di), .do_pin(dout), .do_oe(doe),
        .soft_reset(srst));

    // Shortened reset busy time keeps the run brief
    frp_cmd #(.RST_CYCLES(20)) DUT (.REF_CLK(clk), .RST(rst), .CS_N(cs_n), .SCLK(sclk),
        .DI(di), .QPI_MODE(qpi), .BUSY(busy), .CONT_READ_MODE_BITS(crm),
        .CONT_READ_ACTIVE(cra), .DO(dout), .DO_OE(doe), .DEEP_SLEEP(ds), .RECOVERING(rec),
        .ABORT_OP(), .SOFT_RESET(srst), .WRITE_PERMIT_LATCH_CLR(), .READ_PARAMETER_BITS(rpb),
        .WRAP_LENGTH_BITS(wlb));

    task automatic complete_run();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run

    // Result is {reset seen, output enabled, last 24 bits read}
    task automatic go(input logic [31:0] tx, input int nb, nr, input logic [25:0] e);
        exp_q.push_back(e);
        host.frame(tx, nb, nr, 5);
    endtask : go

    task automatic check_frame(input logic [25:0] e, input logic [25:0] g);
        compares++;
        if (e !== g) begin
            fail_count++;
            $display("MISMATCH frame_result exp=%h got=%h", e, g);
        end
    endtask : check_frame

    // State is {power-down, recovering, read parameters, wrap bits}
    task automatic check_state(input logic [12:0] e);
        logic [12:0] g;
        g = {ds, rec, rpb, wlb};
        compares++;
        if (e !== g) begin
            fail_count++;
            $display("MISMATCH power_state exp=%h got=%h", e, g);
        end
    endtask : check_state

    // Oldest note is matched against each finished frame
    always @(host.done) begin
        logic [25:0] e;
        e = exp_q.pop_front();
        check_frame(e, host.res);
    end

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            fail_count++;
            complete_run();
        end
    end

    initial begin
        void'($urandom(82));
        repeat (10) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        go({8'hAB, 24'($urandom)}, 32, 24, {2'b01, DV, DV, DV});
        go({8'h90, 24'h000000}, 32, 16, {2'b01, 8'h00, MF, DV});
        go({8'h90, 24'h000001}, 32, 24, {2'b01, DV, MF, DV});
        go({8'h9F, 24'h0}, 8, 24, {2'b01, MF, MT, CP});
        qpi = 1'b1;
        go({8'hAF, 24'h0}, 8, 24, {2'b01, MF, MT, CP});
        qpi = 1'b0;
        go({8'hAF, 24'h0}, 8, 24, 26'h0);
        busy = 1'b1;
        go({8'hAB, 24'($urandom)}, 32, 8, 26'h0);
        busy = 1'b0;
        go({8'h66, 24'h0}, 8, 0, 26'h0);
        go({8'h99, 24'h0}, 8, 0, {2'b10, 24'h0});
        check_state({2'b00, frp_pkg::RP_RESET, frp_pkg::WRAP_RESET});
        go({8'h66, 24'h0}, 8, 0, 26'h0);
        go({8'h05, 24'h0}, 8, 0, 26'h0);
        go({8'h99, 24'h0}, 8, 0, 26'h0);
        go({8'h66, 24'h0}, 8, 0, 26'h0);
        exp_q.push_back(26'h0);
        host.frame({8'h99, 24'h0}, 8, 0, 1);
        for (int i = 0; i < 2; i++) begin
            {cra, crm} = i ? 3'h4 : 3'h2;
            go({8'h66, 24'h0}, 8, 0, 26'h0);
            go({8'h99, 24'h0}, 8, 0, 26'h0);
        end
        {cra, crm} = 3'h0;
        go({8'hB9, 24'h0}, 9, 0, 26'h0);
        go({8'h9F, 24'h0}, 8, 24, {2'b01, MF, MT, CP});
        go({8'hB9, 24'h0}, 8, 0, 26'h0);
        repeat (400) @(negedge clk);
        check_state({2'b10, frp_pkg::RP_RESET, frp_pkg::WRAP_RESET});
        go({8'h9F, 24'h0}, 8, 24, 26'h0);
        go({8'h66, 24'h0}, 8, 0, 26'h0);
        go({8'h99, 24'h0}, 8, 0, 26'h0);
        go({8'hAB, 24'h0}, 8, 0, 26'h0);
        check_state({2'b01, frp_pkg::RP_RESET, frp_pkg::WRAP_RESET});
        go({8'h9F, 24'h0}, 8, 24, 26'h0);
        repeat (400) @(negedge clk);
        check_state({2'b00, frp_pkg::RP_RESET, frp_pkg::WRAP_RESET});
        go({8'h9F, 24'h0}, 8, 24, {2'b01, MF, MT, CP});
        // Wake with ID read: the host then waits out the release time, the same as without the ID read
        go({8'hB9, 24'h0}, 8, 0, 26'h0);
        repeat (400) @(negedge clk);
        go({8'hAB, 24'($urandom)}, 32, 24, {2'b01, DV, DV, DV});
        check_state({2'b01, frp_pkg::RP_RESET, frp_pkg::WRAP_RESET});
        repeat (400) @(negedge clk);
        go({8'h9F, 24'h0}, 8, 24, {2'b01, MF, MT, CP});
        complete_run();
    end
endmodule : tb_top
